// File: smbus_clkgen_pkg.sv
// shared constants for the smbus configuration port and clock gating
// assumes both ends and the bench compile this package first
package smbus_clkgen_pkg;
  // bus addresses with the direction bit appended
  localparam logic [7:0] WR_ADDR = 8'hd2;
  localparam logic [7:0] RD_ADDR = 8'hd3;
  // configuration byte file
  localparam int NUM_BYTES = 16;
  localparam int BYTE_CTRL = 0;
  localparam int BYTE_SE_EN = 2;
  localparam int BYTE_DIFF_EN = 3;
  localparam int BYTE_PARK = 4;
  localparam int BYTE_LEN = 8;
  localparam int BYTE_SWING = 9;
  // field positions
  localparam int KEEP_BIT = 0;
  localparam int PARK_BIT = 0;
  localparam int SWING_LSB = 0;
  localparam int SWING_W = 3;
  localparam int LEN_W = 4;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] EN_RST = 8'hff;
  localparam logic [7:0] LEN_RST = 8'h0f;
  localparam logic [7:0] OTHER_RST = 8'h00;
  // package id nibble, value arbitrary
  localparam logic [3:0] PKG_ID = 4'h5;
  // host register offsets (byte addresses)
  localparam logic [3:0] CMD_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] WBUF_OFS = 4'h8;
  localparam logic [3:0] RBUF_OFS = 4'hc;
  // host command fields
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_RD_BIT = 1;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_CNT_LSB = 16;
  localparam int CMD_CNT_W = 3;
  localparam logic [2:0] CMD_CNT_MAX = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // link timing: a quarter of an scl period, least time
  localparam int SYS_PERIOD_NS = 100;
  localparam int QUARTER_NS = 2500;
  localparam int QUARTER_CYC = (QUARTER_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
endpackage

// File: smbus_link_if.sv
// two-wire management link between the host and the clock generator
// assumes pull-ups: a line is low whenever any party enables its driver
`timescale 1ns/1ps
interface smbus_link_if;
  logic scl_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // open-drain wired-and resolved here, not in the ends
  assign scl = ~scl_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport host (output scl_oe, output sda_host_oe, input scl, input sda);
  modport device (output sda_dev_oe, input scl, input sda);
endinterface

// File: clkgen_dev.sv
// clock generator end: smbus configuration slave and output gating
// assumes link_clk_in free running, several times faster than scl
//
// Added by the designer: the address map; the AXI4-Lite interface to the registers sits in smbus_host, not here.
`timescale 1ns/1ps
module clkgen_dev #(
  parameter int NSE = 8,
  parameter int NDIFF = 8,
  parameter logic [NSE-1:0] SE_STOP = 8'h1f,
  parameter logic [NSE-1:0] SE_LATCH = 8'hc0,
  parameter logic [NDIFF-1:0] DIFF_PCI = 8'h3c,
  parameter logic [NDIFF-1:0] DIFF_CPU = 8'h03,
  parameter logic [NDIFF-1:0] DIFF_CREQ = 8'hc0
) (
  // link side
  input wire logic link_clk_in,
  smbus_link_if.device link,
  // core clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // power management pins
  input wire logic pci_halt_n_in,
  input wire logic cpu_halt_n_in,
  input wire logic clock_request_n_in,
  input wire logic power_down_n_in,
  input wire logic management_mode_one_in,
  // gated clock outputs
  output logic [NSE-1:0] se_clk_out,
  output logic [NSE-1:0] se_oe_out,
  output logic [NDIFF-1:0] diff_true_out,
  output logic [NDIFF-1:0] diff_true_oe_out,
  output logic [NDIFF-1:0] diff_comp_out,
  output logic [2:0] swing_sel_out
);
  typedef enum {S_IDLE, S_ADDR, S_INDEX, S_COUNT, S_WRITE, S_SEND} link_state_t;

  link_state_t state_q;
  logic [1:0] scl_sync_q, sda_sync_q, pd_sync_q;
  logic scl_prev_q, sda_prev_q, pd_prev_q;
  logic [3:0] cnt_q;
  logic slot_q, nak_q, sent_cnt_q, sda_oe_q, latches_q;
  logic [7:0] rx_q, tx_q, ptr_q, wleft_q;
  // the byte file size is needed before the file is declared
  localparam int NUM_BYTES_L = smbus_clkgen_pkg::NUM_BYTES;
  logic [7:0] cfg_q [NUM_BYTES_L];
  logic scl_rise, scl_fall, start_seen, stop_seen, cfg_we, wake_clear;
  logic [7:0] rd_byte, len_byte;

  function automatic logic [7:0] cfg_reset(input int i);
    if (i == smbus_clkgen_pkg::BYTE_CTRL) return smbus_clkgen_pkg::CTRL_RST;
    if (i == smbus_clkgen_pkg::BYTE_SE_EN) return smbus_clkgen_pkg::EN_RST;
    if (i == smbus_clkgen_pkg::BYTE_DIFF_EN) return smbus_clkgen_pkg::EN_RST;
    if (i == smbus_clkgen_pkg::BYTE_LEN) return smbus_clkgen_pkg::LEN_RST;
    return smbus_clkgen_pkg::OTHER_RST;
  endfunction

  // both lines pass two flops before anything looks at them
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      pd_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      pd_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      pd_sync_q <= {pd_sync_q[0], power_down_n_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
      pd_prev_q <= pd_sync_q[1];
    end
  end

  assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
  assign start_seen = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
  assign stop_seen = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
  assign link.sda_dev_oe = sda_oe_q;

  // reported count is the programmed length field
  assign len_byte = {4'h0, cfg_q[smbus_clkgen_pkg::BYTE_LEN][3:0]};
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == 8'(smbus_clkgen_pkg::BYTE_LEN))
      rd_byte = {smbus_clkgen_pkg::PKG_ID, len_byte[3:0]};
    else if (ptr_q < 8'(NUM_BYTES_L))
      rd_byte = cfg_q[ptr_q[3:0]];
  end

  // a write lands only inside the announced count and the byte file
  assign cfg_we = scl_fall & (cnt_q == 4'h8) & ~slot_q & (state_q == S_WRITE)
    & (wleft_q != 8'h00) & (ptr_q < 8'(NUM_BYTES_L));
  assign wake_clear = pd_sync_q[1] & ~pd_prev_q
    & ~cfg_q[smbus_clkgen_pkg::BYTE_CTRL][smbus_clkgen_pkg::KEEP_BIT];

  // byte-level protocol engine, driven on scl edges seen in this domain
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      slot_q <= 1'b0;
      nak_q <= 1'b0;
      sent_cnt_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      wleft_q <= 8'h00;
    end else if (start_seen) begin
      state_q <= S_ADDR;
      cnt_q <= 4'h0;
      slot_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_seen) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      slot_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (state_q != S_IDLE) begin
      if (scl_rise) begin
        if (cnt_q != 4'h8) begin
          rx_q <= {rx_q[6:0], sda_sync_q[1]};
          cnt_q <= cnt_q + 4'h1;
        end else begin
          nak_q <= sda_sync_q[1];
        end
      end else if (scl_fall) begin
        if (cnt_q == 4'h8 && !slot_q) begin
          slot_q <= 1'b1;
          unique case (state_q)
            S_ADDR: begin
              sent_cnt_q <= 1'b0;
              if (rx_q == smbus_clkgen_pkg::WR_ADDR) begin
                sda_oe_q <= 1'b1;
                state_q <= S_INDEX;
              end else if (rx_q == smbus_clkgen_pkg::RD_ADDR) begin
                sda_oe_q <= 1'b1;
                state_q <= S_SEND;
              end else begin
                sda_oe_q <= 1'b0;
                state_q <= S_IDLE;
              end
            end
            S_INDEX: begin
              ptr_q <= rx_q;
              sda_oe_q <= 1'b1;
              state_q <= S_COUNT;
            end
            S_COUNT: begin
              wleft_q <= rx_q;
              sda_oe_q <= 1'b1;
              state_q <= S_WRITE;
            end
            S_WRITE: begin
              sda_oe_q <= 1'b1;
              if (wleft_q != 8'h00) begin
                ptr_q <= ptr_q + 8'h01;
                wleft_q <= wleft_q - 8'h01;
              end
            end
            S_SEND: sda_oe_q <= 1'b0;
            S_IDLE: sda_oe_q <= 1'b0;
          endcase
        end else if (slot_q) begin
          slot_q <= 1'b0;
          cnt_q <= 4'h0;
          sda_oe_q <= 1'b0;
          if (state_q == S_SEND) begin
            if (nak_q) begin
              state_q <= S_IDLE;
            end else if (!sent_cnt_q) begin
              sent_cnt_q <= 1'b1;
              tx_q <= len_byte;
              sda_oe_q <= ~len_byte[7];
            end else begin
              tx_q <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end else if (state_q == S_SEND) begin
          sda_oe_q <= ~tx_q[6];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // configuration file; latches open after a clearing wake
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      latches_q <= 1'b0;
      for (int i = 0; i < NUM_BYTES_L; i++) cfg_q[i] <= cfg_reset(i);
    end else if (wake_clear) begin
      latches_q <= 1'b1;
      for (int i = 0; i < NUM_BYTES_L; i++) cfg_q[i] <= cfg_reset(i);
    end else if (cfg_we) begin
      cfg_q[ptr_q[3:0]] <= rx_q;
      latches_q <= 1'b0;
    end
  end

  // ---- output clock domain ----
  localparam int XW = NSE + NDIFF + 5;
  logic [1:0][4:0] pin_sync_q;
  logic [1:0][XW-1:0] xcfg_sync_q;
  logic [XW-1:0] xcfg;
  logic pci_ok, cpu_ok, creq_ok, pd_now, m1_now, lo_now, park_style;
  logic [NSE-1:0] se_en, se_run_d, se_hiz_d, se_run_q, se_hiz_q;
  logic [NDIFF-1:0] diff_en, run_d, hi_d, run_q, hi_q;
  logic phase_q;

  // settings are quasi-static, so a plain two-flop crossing is enough
  assign xcfg = {cfg_q[smbus_clkgen_pkg::BYTE_SE_EN][NSE-1:0],
    cfg_q[smbus_clkgen_pkg::BYTE_DIFF_EN][NDIFF-1:0],
    cfg_q[smbus_clkgen_pkg::BYTE_PARK][smbus_clkgen_pkg::PARK_BIT],
    latches_q,
    cfg_q[smbus_clkgen_pkg::BYTE_SWING][smbus_clkgen_pkg::SWING_LSB +:
      smbus_clkgen_pkg::SWING_W]};

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_sync_q <= '1;
      xcfg_sync_q <= '0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], {pci_halt_n_in, cpu_halt_n_in,
        clock_request_n_in, power_down_n_in, ~management_mode_one_in}};
      xcfg_sync_q <= {xcfg_sync_q[0], xcfg};
    end
  end

  assign {pci_ok, cpu_ok, creq_ok} = pin_sync_q[1][4:2];
  assign pd_now = ~pin_sync_q[1][1];
  assign m1_now = ~pin_sync_q[1][0];
  assign {se_en, diff_en, park_style, lo_now} = xcfg_sync_q[1][XW-1:3];

  // gating decision per output, highest priority first
  always_comb begin
    for (int i = 0; i < NDIFF; i++) begin
      run_d[i] = 1'b0;
      hi_d[i] = 1'b0;
      if (lo_now || pd_now) begin
        run_d[i] = 1'b0;
      end else if (m1_now) begin
        run_d[i] = (i == 0);
      end else if (!diff_en[i]) begin
        run_d[i] = 1'b0;
      end else if (DIFF_CREQ[i] && !creq_ok) begin
        run_d[i] = 1'b0;
      end else if ((DIFF_PCI[i] && !pci_ok) || (DIFF_CPU[i] && !cpu_ok)) begin
        hi_d[i] = ~park_style;
      end else begin
        run_d[i] = 1'b1;
      end
    end
    for (int i = 0; i < NSE; i++) begin
      se_run_d[i] = 1'b0;
      se_hiz_d[i] = 1'b0;
      if (lo_now || pd_now || m1_now) se_hiz_d[i] = SE_LATCH[i];
      else if (!se_en[i]) se_run_d[i] = 1'b0;
      else if (SE_STOP[i] && !pci_ok) se_run_d[i] = 1'b0;
      else se_run_d[i] = 1'b1;
    end
  end

  // modes change only as the output clock enters its low half
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_q <= 1'b0;
      run_q <= '0;
      hi_q <= '0;
      se_run_q <= '0;
      se_hiz_q <= '0;
    end else begin
      phase_q <= ~phase_q;
      if (phase_q) begin
        run_q <= run_d;
        hi_q <= hi_d;
        se_run_q <= se_run_d;
        se_hiz_q <= se_hiz_d;
      end
    end
  end

  // registered pins; a released true output is pulled down outside
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      diff_true_out <= '0;
      diff_true_oe_out <= '0;
      diff_comp_out <= '0;
      se_clk_out <= '0;
      se_oe_out <= '1;
      swing_sel_out <= 3'h0;
    end else begin
      diff_true_out <= (run_q & {NDIFF{~phase_q}}) | hi_q;
      diff_true_oe_out <= run_q | hi_q;
      diff_comp_out <= run_q & {NDIFF{phase_q}};
      se_clk_out <= se_run_q & {NSE{~phase_q}};
      se_oe_out <= ~se_hiz_q;
      swing_sel_out <= xcfg_sync_q[1][2:0];
    end
  end
endmodule // clkgen_dev

// File: smbus_host.sv
// host end: axi4-lite command registers and smbus block master
// assumes the device answers within the scl quarter timing below
`timescale 1ns/1ps
module smbus_host #(
  parameter int QCYC = smbus_clkgen_pkg::QUARTER_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // axi4-lite slave
  input wire logic [3:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [3:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // link
  smbus_link_if.host link
);
  typedef enum {H_IDLE, H_START, H_BITS, H_STOP} host_state_t;

  host_state_t hs_q;
  logic [3:0] aw_q;
  logic [31:0] wd_q, cmd_q, wbuf_q, rbuf_q;
  logic [3:0] ws_q;
  logic aw_have_q, w_have_q, go_q, busy_q, nack_q, rd_mode;
  logic [15:0] div_q;
  logic [1:0] q_q;
  logic [3:0] bit_q, item_q, last_item;
  logic [7:0] rxb_q, rcnt_q, cur_byte;
  logic [1:0] sda_sync_q;
  logic scl_oe_q, sda_oe_q, tick, is_rx;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction

  // write channel: address and data taken in either order
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= smbus_clkgen_pkg::RESP_OKAY;
      aw_q <= 4'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      cmd_q <= 32'h0;
      wbuf_q <= 32'h0;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (awvalid_in && awready_out) begin
        aw_q <= awaddr_in;
        aw_have_q <= 1'b1;
        awready_out <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        wd_q <= wdata_in;
        ws_q <= wstrb_in;
        w_have_q <= 1'b1;
        wready_out <= 1'b0;
      end
      if (aw_have_q && w_have_q && !bvalid_out) begin
        bvalid_out <= 1'b1;
        bresp_out <= smbus_clkgen_pkg::RESP_OKAY;
        unique case (aw_q)
          smbus_clkgen_pkg::CMD_OFS: if (!busy_q) begin
            cmd_q <= merge(cmd_q, wd_q, ws_q);
            go_q <= ws_q[0] & wd_q[smbus_clkgen_pkg::CMD_GO_BIT];
          end
          smbus_clkgen_pkg::WBUF_OFS: wbuf_q <= merge(wbuf_q, wd_q, ws_q);
          smbus_clkgen_pkg::STAT_OFS, smbus_clkgen_pkg::RBUF_OFS: ;
          default: bresp_out <= smbus_clkgen_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0;
      rresp_out <= smbus_clkgen_pkg::RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rresp_out <= smbus_clkgen_pkg::RESP_OKAY;
      unique case (araddr_in)
        smbus_clkgen_pkg::CMD_OFS: rdata_out <= {cmd_q[31:1], busy_q};
        smbus_clkgen_pkg::STAT_OFS:
          rdata_out <= {16'h0, rcnt_q, 6'h0, nack_q, busy_q};
        smbus_clkgen_pkg::WBUF_OFS: rdata_out <= wbuf_q;
        smbus_clkgen_pkg::RBUF_OFS: rdata_out <= rbuf_q;
        default: begin
          rdata_out <= 32'h0;
          rresp_out <= smbus_clkgen_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
      arready_out <= 1'b1;
    end
  end

  // sequence of bytes: write d2,n,x,data / read d2,n,(rs)d3,count,data
  assign rd_mode = cmd_q[smbus_clkgen_pkg::CMD_RD_BIT];
  assign last_item = {1'b0, cmd_q[smbus_clkgen_pkg::CMD_CNT_LSB +:
    smbus_clkgen_pkg::CMD_CNT_W]} + (rd_mode ? 4'h3 : 4'h2);
  assign is_rx = rd_mode && item_q >= 4'h3;
  always_comb begin
    // lane index wraps in two bits: item 3 is data byte 0
    cur_byte = wbuf_q[8*2'(item_q[1:0] + 2'h1) +: 8];
    if (item_q == 4'h0) cur_byte = smbus_clkgen_pkg::WR_ADDR;
    else if (item_q == 4'h1) cur_byte = cmd_q[15:8];
    else if (item_q == 4'h2 && rd_mode) cur_byte = smbus_clkgen_pkg::RD_ADDR;
    else if (item_q == 4'h2) cur_byte = {5'h0,
      cmd_q[smbus_clkgen_pkg::CMD_CNT_LSB +: smbus_clkgen_pkg::CMD_CNT_W]};
  end

  assign tick = div_q == 16'(QCYC - 1);
  assign link.scl_oe = scl_oe_q;
  assign link.sda_host_oe = sda_oe_q;

  // bit engine, four quarter ticks per bit
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_sync_q <= 2'h3;
      hs_q <= H_IDLE;
      div_q <= 16'h0;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      item_q <= 4'h0;
      rxb_q <= 8'h0;
      rcnt_q <= 8'h0;
      rbuf_q <= 32'h0;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      sda_sync_q <= {sda_sync_q[0], link.sda};
      div_q <= tick ? 16'h0 : div_q + 16'h1;
      if (hs_q == H_IDLE) begin
        if (go_q) begin
          hs_q <= H_START;
          busy_q <= 1'b1;
          nack_q <= 1'b0;
          item_q <= 4'h0;
          q_q <= 2'h0;
        end
      end else if (tick) begin
        q_q <= q_q + 2'h1;
        unique case (hs_q)
          H_START: begin
            unique case (q_q)
              2'h0: begin scl_oe_q <= 1'b1; sda_oe_q <= 1'b0; end
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              2'h3: begin scl_oe_q <= 1'b1; hs_q <= H_BITS; bit_q <= 4'h0; end
            endcase
          end
          H_BITS: begin
            unique case (q_q)
              2'h0: begin
                scl_oe_q <= 1'b1;
                if (bit_q != 4'h8) sda_oe_q <= ~is_rx & ~cur_byte[3'(7 - bit_q)];
                else sda_oe_q <= is_rx & (item_q != last_item);
              end
              2'h1: ;
              2'h2: scl_oe_q <= 1'b0;
              2'h3: begin
                if (bit_q != 4'h8) begin
                  rxb_q <= {rxb_q[6:0], sda_sync_q[1]};
                  bit_q <= bit_q + 4'h1;
                end else begin
                  bit_q <= 4'h0;
                  if (is_rx && item_q == 4'h3) rcnt_q <= rxb_q;
                  else if (is_rx) rbuf_q[8*(item_q[1:0]) +: 8] <= rxb_q;
                  if (!is_rx && sda_sync_q[1]) begin
                    nack_q <= 1'b1;
                    hs_q <= H_STOP;
                  end else if (item_q == last_item) begin
                    hs_q <= H_STOP;
                  end else begin
                    item_q <= item_q + 4'h1;
                    if (rd_mode && item_q == 4'h1) hs_q <= H_START;
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (q_q)
              2'h0: begin scl_oe_q <= 1'b1; sda_oe_q <= 1'b1; end
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0;
              2'h3: begin hs_q <= H_IDLE; busy_q <= 1'b0; end
            endcase
          end
          H_IDLE: ;
        endcase
      end
    end
  end
endmodule // smbus_host

// File: smbus_link_sva.sv
// checker of the two link wires between host and generator
// assumes the bench places it beside the one link interface
`timescale 1ns/1ps
module smbus_link_sva #(
  parameter int QCYC = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // link wires
  input wire logic scl_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int QEND = QCYC + 2;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);
  // sda may move under a high scl only to frame a transfer
  sequence s_start;
    scl && $fell(sda);
  endsequence
  a_scl_pull_up: assert property (scl == !scl_oe)
    else $error("scl level wrong");
  a_sda_wired: assert property (sda == !(sda_host_oe | sda_dev_oe))
    else $error("sda level wrong");
  a_start_low: assert property (s_start |-> ##[1:QEND] !scl)
    else $error("start without clock low");
  a_stop_idle: assert property (scl && $rose(sda) |=> scl [*8])
    else $error("clock moved after stop");
  a_scl_low_hold: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase short");
  a_scl_high_hold: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase short");
  a_ack_on_low: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("device drove sda under high clock");
  a_dev_data_held: assert property (
    scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device data moved under high clock");
endmodule // smbus_link_sva

// File: smbus_config_and_clock_gating_tb.sv
// bench: host and clock generator joined by the link
// assumes package, interface and both ends compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  n_errors++; $display("BAD %0t got %h want %h", $time, a, b); end end
module smbus_config_and_clock_gating_tb;
  // driven inputs, all valued at time zero
  logic sys_clk_in = 1'h0, link_clk_in = 1'h0, nrst_in = 1'h0;
  logic [3:0] awaddr_in = 4'h0, araddr_in = 4'h0, wstrb_in = 4'hf;
  logic [31:0] wdata_in = 32'h0, rdata_out, rb, seed = 32'h000175c9;
  logic awvalid_in = 1'h0, wvalid_in = 1'h0, bready_in = 1'h0;
  logic arvalid_in = 1'h0, rready_in = 1'h0, pci_halt_n_in = 1'h1;
  logic cpu_halt_n_in = 1'h1, clock_request_n_in = 1'h1;
  logic power_down_n_in = 1'h1, management_mode_one_in = 1'h0;
  // observed outputs and shadow of the configuration bytes
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out, rs;
  logic [7:0] se_clk_out, se_oe_out, diff_comp_out, mem [16];
  logic [7:0] diff_true_out, diff_true_oe_out;
  logic [2:0] swing_sel_out;
  int n_errors = 0, n_compared = 0, cyc = 0, i0, c0;
  smbus_link_if link ();
  smbus_host #(.QCYC(8)) smbus_host_inst (.*, .link(link));
  clkgen_dev clkgen_dev_inst (.*, .link(link));
  smbus_link_sva #(.QCYC(8)) smbus_link_sva_inst (.*,
    .scl_oe(link.scl_oe), .sda_host_oe(link.sda_host_oe),
    .sda_dev_oe(link.sda_dev_oe), .scl(link.scl), .sda(link.sda));
  // link clock free running, phase unrelated to the system clock
  always #50 sys_clk_in = ~sys_clk_in;
  always #80 link_clk_in = ~link_clk_in;
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well above the longest expected run
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      conclude();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // index past the file reads zero; byte 8 carries the package id
  function automatic logic [7:0] expb(input int k);
    if (k > 15) return 8'h00;
    if (k == 8) return {smbus_clkgen_pkg::PKG_ID, mem[8][3:0]};
    return mem[k];
  endfunction
  task automatic dflt();
    foreach (mem[k]) mem[k] = 8'h00;
    {mem[0], mem[2], mem[3], mem[8]} = 32'h01ffff0f;
  endtask
  task automatic settle();
    repeat (12) @(posedge sys_clk_in);
  endtask
  // axi4-lite write: address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit ta, tw;
    @(posedge sys_clk_in);
    {ta, tw} = 2'h0;
    {awaddr_in, wdata_in} <= {a, d};
    {awvalid_in, wvalid_in, bready_in} <= 3'h7;
    while (!(ta && tw)) begin
      @(posedge sys_clk_in);
      ta |= awready_out;
      tw |= wready_out;
      if (ta) awvalid_in <= 1'h0;
      if (tw) wvalid_in <= 1'h0;
    end
    while (bvalid_out !== 1'h1) @(posedge sys_clk_in);
    bready_in <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    araddr_in <= a;
    {arvalid_in, rready_in} <= 2'h3;
    do @(posedge sys_clk_in); while (arready_out !== 1'h1);
    arvalid_in <= 1'h0;
    do @(posedge sys_clk_in); while (rvalid_out !== 1'h1);
    rready_in <= 1'h0;
    {rb, rs} = {rdata_out, rresp_out};
  endtask
  // one block transfer through the host registers, then compare
  task automatic xfer(input bit rd_n, input int idx, cnt,
                      input logic [31:0] wd);
    for (int i = 0; i < cnt; i++)
      if (!rd_n && idx + i < 16) mem[idx + i] = wd[8*i +: 8];
    wr(smbus_clkgen_pkg::WBUF_OFS, wd);
    wr(smbus_clkgen_pkg::CMD_OFS,
       {13'h0, cnt[2:0], idx[7:0], 6'h0, rd_n, 1'h1});
    do rd(smbus_clkgen_pkg::STAT_OFS); while (rb[0] !== 1'h0);
    `CHK(rb[1], 1'h0)
    if (rd_n) begin
      `CHK(rb[15:8], {4'h0, mem[8][3:0]})
      rd(smbus_clkgen_pkg::RBUF_OFS);
      for (int i = 0; i < cnt; i++) `CHK(rb[8*i +: 8], expb(idx + i))
    end
  endtask
  initial begin
    dflt();
    repeat (4) @(posedge sys_clk_in);
    nrst_in <= 1'h1;
    rd(4'h6);
    `CHK(rs, smbus_clkgen_pkg::RESP_SLVERR)
    xfer(1'h1, 0, 4, 0);
    xfer(1'h0, 8, 1, 3);
    xfer(1'h1, 7, 3, 0);
    xfer(1'h0, 14, 4, rnd());
    xfer(1'h1, 14, 4, 0);
    repeat (6) begin
      i0 = 9 + rnd() % 7;
      c0 = 1 + rnd() % 4;
      xfer(1'h0, i0, c0, rnd());
      xfer(1'h1, i0, c0, 0);
      `CHK(swing_sel_out, mem[9][2:0])
    end
    pci_halt_n_in <= 1'h0;
    settle();
    `CHK({diff_true_out[5:2], diff_comp_out[5:2]}, 8'hf0)
    `CHK({diff_true_oe_out[5:2], se_clk_out[4:0]}, 9'h1e0)
    xfer(1'h0, 4, 1, 1);
    settle();
    `CHK({diff_true_oe_out[5:2], diff_comp_out[5:2]}, 8'h00)
    {pci_halt_n_in, cpu_halt_n_in} <= 2'h2;
    settle();
    `CHK({diff_true_oe_out[5:0], diff_comp_out[1:0]}, 8'hf0)
    {cpu_halt_n_in, clock_request_n_in} <= 2'h2;
    settle();
    `CHK({diff_true_oe_out, diff_comp_out[7:6]}, 10'h0fc)
    clock_request_n_in <= 1'h1;
    xfer(1'h0, 3, 1, 32'hfb);
    settle();
    `CHK({diff_true_oe_out, diff_comp_out[2]}, 9'h1f6)
    management_mode_one_in <= 1'h1;
    settle();
    `CHK({diff_true_oe_out, se_oe_out[7:6], se_clk_out[5:0]}, 16'h0100)
    management_mode_one_in <= 1'h0;
    xfer(1'h0, 0, 1, 0);
    power_down_n_in <= 1'h0;
    settle();
    `CHK({diff_true_oe_out, diff_comp_out, se_clk_out[5:0]}, 22'h0)
    power_down_n_in <= 1'h1;
    settle();
    `CHK(diff_true_oe_out, 8'h00)
    dflt();
    xfer(1'h1, 8, 2, 0);
    `CHK(swing_sel_out, 3'h0)
    conclude();
  end
endmodule // smbus_config_and_clock_gating_tb
